// file: design/gpcft_pkg.sv
// Constants for the output pin and FIFO threshold configuration bank
`default_nettype none
package gpcft_pkg;
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_PIN_TWO = 6'h00;
   localparam logic [5:0] OFF_PIN_ONE = 6'h01;
   localparam logic [5:0] OFF_PIN_ZERO = 6'h02;
   localparam logic [5:0] OFF_QUEUE_FILL_THRESHOLD = 6'h03;
   // Field positions
   localparam int SEL_MSB = 5;
   localparam int POL_BIT = 6;
   localparam int TOP_BIT = 7;
   localparam int THR_MSB = 3;
   localparam int ATT_LSB = 4;
   localparam int ATT_MSB = 5;
   localparam int KEEP_BIT = 6;
   // Reset values
   localparam logic [7:0] RST_PIN_TWO = 8'h29;
   localparam logic [7:0] RST_PIN_ONE = 8'h2E;
   localparam logic [7:0] RST_PIN_ZERO = 8'h3F;
   localparam logic [7:0] RST_QUEUE_FILL_THRESHOLD = 8'h07;
   // Select codes with fixed meaning here
   localparam logic [5:0] SEL_CHIP_READY = 6'h29;
   localparam logic [5:0] SEL_HIGH_Z = 6'h2E;
   localparam logic [5:0] SEL_OSC_DIV = 6'h3F;
   // Oscillator divided output
   localparam int CLK_MHZ = 25;
   localparam int OSC_DIV = 192;
   localparam logic [6:0] OSC_HALF_LAST = 7'(OSC_DIV / 2 - 1);
   // Threshold tables
   localparam logic [6:0] TX_LEVEL_BASE = 7'd61;
   localparam logic [6:0] RX_LEVEL_BASE = 7'd4;
   localparam logic [4:0] ATT_STEP_DB = 5'd6;
   localparam int FILL_W = 7;
endpackage : gpcft_pkg
`default_nettype wire

// file: design/gpcft_pin_driver.sv
// One general-purpose output pin: source select, polarity and three-state
`timescale 1ns/1ps
`default_nettype none
module gpcft_pin_driver (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Configuration
   input wire logic [5:0] select,
   input wire logic polarity,
   input wire logic analog_mode,
   // Internal signal sources, indexed by select code
   input wire logic [63:0] sources,
   // Pin
   output logic pin_out,
   output logic pin_oe
);
   import gpcft_pkg::*;
   logic next_pin_out;
   logic next_pin_oe;

   always_comb begin
      next_pin_out = sources[select] ^ polarity;
      // Analog sensor owns the pin, so the digital driver lets go
      next_pin_oe = (select != SEL_HIGH_Z) && !analog_mode;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end
endmodule : gpcft_pin_driver
`default_nettype wire

// file: design/gpcft_config_bank.sv
// Output pin and FIFO threshold configuration register bank
`timescale 1ns/1ps
`default_nettype none
// Contract
// - All four registers keep their contents through sleep.
// - Bit 6 of each pin register inverts that pin's signal, reset 0.
// - Pin two select is bits 5:0, reset 0x29, routing the chip-ready low signal.
// - Pin one select resets to 0x2E, leaving the pin three-stated.
// - Pin zero select resets to 0x3F, driving the oscillator clock divided by 192.
// - Bit 7 of the pin one register sets drive strength for all pins, 1 high, reset 0.
// - A threshold flag rises when FIFO fill is at or above the level picked by the 4-bit threshold (rx 4 + 4*thr, tx 61 - 4*thr), reset 0111.
module gpcft_config_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [gpcft_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Power state
   input wire logic sleep,
   // Signal sources and FIFO fill levels
   input wire logic [63:0] sources,
   input wire logic chip_ready_low,
   input wire logic [gpcft_pkg::FILL_W-1:0] tx_fifo_bytes,
   input wire logic [gpcft_pkg::FILL_W-1:0] rx_fifo_bytes,
   // Output pins
   output logic gp_output_two,
   output logic gp_output_two_oe,
   output logic gp_output_one,
   output logic gp_output_one_oe,
   output logic gp_output_zero,
   output logic gp_output_zero_oe,
   // Analog controls
   output logic output_drive_strength,
   output logic temp_sensor_enable,
   output logic converter_keep_setting,
   output logic [4:0] rx_atten_db,
   // Threshold flags
   output logic tx_threshold_reached,
   output logic rx_threshold_reached
);
   import gpcft_pkg::*;

   function automatic logic [6:0] rx_level(input logic [3:0] thr);
      rx_level = RX_LEVEL_BASE + {1'b0, thr, 2'b00};
   endfunction : rx_level

   function automatic logic [6:0] tx_level(input logic [3:0] thr);
      tx_level = TX_LEVEL_BASE - {1'b0, thr, 2'b00};
   endfunction : tx_level

   logic [7:0] output_pin_two_config;
   logic [7:0] output_pin_one_config;
   logic [7:0] output_pin_zero_config;
   logic [7:0] fifo_threshold_config;
   logic [7:0] next_output_pin_two_config;
   logic [7:0] next_output_pin_one_config;
   logic [7:0] next_output_pin_zero_config;
   logic [7:0] next_fifo_threshold_config;
   logic [7:0] next_reg_rdata;
   logic [3:0] queue_fill_threshold;

   assign queue_fill_threshold = fifo_threshold_config[THR_MSB:0];

   // Register writes; sleep has no effect on contents
   always_comb begin
      next_output_pin_two_config = output_pin_two_config;
      next_output_pin_one_config = output_pin_one_config;
      next_output_pin_zero_config = output_pin_zero_config;
      next_fifo_threshold_config = fifo_threshold_config;
      if (reg_write) begin
         unique case (reg_addr)
            OFF_PIN_TWO: next_output_pin_two_config = {1'b0, reg_wdata[POL_BIT:0]};
            OFF_PIN_ONE: next_output_pin_one_config = reg_wdata;
            OFF_PIN_ZERO: next_output_pin_zero_config = reg_wdata;
            OFF_QUEUE_FILL_THRESHOLD: next_fifo_threshold_config = reg_wdata;
            default: ;
         endcase
      end
      unique case (reg_addr)
         OFF_PIN_TWO: next_reg_rdata = output_pin_two_config;
         OFF_PIN_ONE: next_reg_rdata = output_pin_one_config;
         OFF_PIN_ZERO: next_reg_rdata = output_pin_zero_config;
         OFF_QUEUE_FILL_THRESHOLD: next_reg_rdata = fifo_threshold_config;
         default: next_reg_rdata = 8'h00;
      endcase
      if (!reg_read) begin
         next_reg_rdata = reg_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         output_pin_two_config <= RST_PIN_TWO;
         output_pin_one_config <= RST_PIN_ONE;
         output_pin_zero_config <= RST_PIN_ZERO;
         fifo_threshold_config <= RST_QUEUE_FILL_THRESHOLD;
         reg_rdata <= 8'h00;
      end else begin
         output_pin_two_config <= next_output_pin_two_config;
         output_pin_one_config <= next_output_pin_one_config;
         output_pin_zero_config <= next_output_pin_zero_config;
         fifo_threshold_config <= next_fifo_threshold_config;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Oscillator divided by 192, taken from the system clock
   logic [6:0] osc_count;
   logic [6:0] next_osc_count;
   logic osc_div_clk;
   logic next_osc_div_clk;

   always_comb begin
      next_osc_count = osc_count + 7'd1;
      next_osc_div_clk = osc_div_clk;
      if (osc_count == OSC_HALF_LAST) begin
         next_osc_count = 7'd0;
         next_osc_div_clk = !osc_div_clk;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         osc_count <= 7'd0;
         osc_div_clk <= 1'b0;
      end else begin
         osc_count <= next_osc_count;
         osc_div_clk <= next_osc_div_clk;
      end
   end

   logic [63:0] pin_sources;
   always_comb begin
      pin_sources = sources;
      pin_sources[SEL_CHIP_READY] = chip_ready_low;
      pin_sources[SEL_OSC_DIV] = osc_div_clk;
   end

   gpcft_pin_driver u_pin_two (
      .clk(clk),
      .reset(reset),
      .select(output_pin_two_config[SEL_MSB:0]),
      .polarity(output_pin_two_config[POL_BIT]),
      .analog_mode(1'b0),
      .sources(pin_sources),
      .pin_out(gp_output_two),
      .pin_oe(gp_output_two_oe)
   );

   gpcft_pin_driver u_pin_one (
      .clk(clk),
      .reset(reset),
      .select(output_pin_one_config[SEL_MSB:0]),
      .polarity(output_pin_one_config[POL_BIT]),
      .analog_mode(1'b0),
      .sources(pin_sources),
      .pin_out(gp_output_one),
      .pin_oe(gp_output_one_oe)
   );

   // Sensor mode (bit 7) releases the pin whatever the other bits of this register hold
   gpcft_pin_driver u_pin_zero (
      .clk(clk),
      .reset(reset),
      .select(output_pin_zero_config[SEL_MSB:0]),
      .polarity(output_pin_zero_config[POL_BIT]),
      .analog_mode(output_pin_zero_config[TOP_BIT]),
      .sources(pin_sources),
      .pin_out(gp_output_zero),
      .pin_oe(gp_output_zero_oe)
   );

   assign output_drive_strength = output_pin_one_config[TOP_BIT];
   assign temp_sensor_enable = output_pin_zero_config[TOP_BIT];
   assign converter_keep_setting = fifo_threshold_config[KEEP_BIT];

   // Threshold flags and attenuation, registered
   logic next_tx_reached;
   logic next_rx_reached;
   logic [4:0] next_rx_atten_db;

   always_comb begin
      next_tx_reached = tx_fifo_bytes >= tx_level(queue_fill_threshold);
      next_rx_reached = rx_fifo_bytes >= rx_level(queue_fill_threshold);
      next_rx_atten_db = 5'(ATT_STEP_DB * fifo_threshold_config[ATT_MSB:ATT_LSB]);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_threshold_reached <= 1'b0;
         rx_threshold_reached <= 1'b0;
         rx_atten_db <= 5'd0;
      end else begin
         tx_threshold_reached <= next_tx_reached;
         rx_threshold_reached <= next_rx_reached;
         rx_atten_db <= next_rx_atten_db;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_write_one;
      reg_write && reg_addr == OFF_PIN_ONE;
   endsequence

   sequence s_write_thr;
      reg_write && reg_addr == OFF_QUEUE_FILL_THRESHOLD;
   endsequence

   property p_sleep_keep;
      sleep && !reg_write |=> $stable(output_pin_two_config) && $stable(output_pin_one_config)
         && $stable(output_pin_zero_config) && $stable(fifo_threshold_config);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("config changed in sleep");

   // Sampled reset keeps the release edge out: pins still hold reset levels there
   property p_two_polarity;
      !reset && output_pin_two_config[SEL_MSB:0] == SEL_CHIP_READY
         |=> gp_output_two == ($past(chip_ready_low) ^ $past(output_pin_two_config[POL_BIT]));
   endproperty
   a_two_polarity: assert property (p_two_polarity) else $error("pin two level wrong");

   property p_reset_values;
      @(posedge clk) disable iff (1'b0)
         reset |=> output_pin_two_config == 8'h29 && output_pin_one_config == 8'h2E
         && output_pin_zero_config == 8'h3F && fifo_threshold_config == 8'h07;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

   property p_high_z;
      output_pin_one_config[SEL_MSB:0] == SEL_HIGH_Z |=> !gp_output_one_oe;
   endproperty
   a_high_z: assert property (p_high_z) else $error("pin one driven in three-state");

   property p_osc_div;
      osc_count == 7'd95 |=> osc_count == 7'd0 && osc_div_clk != $past(osc_div_clk);
   endproperty
   a_osc_div: assert property (p_osc_div) else $error("divided clock period wrong");

   property p_drive;
      s_write_one |=> output_drive_strength == $past(reg_wdata[7]);
   endproperty
   a_drive: assert property (p_drive) else $error("drive strength not updated");

   property p_rx_flag;
      !reset |=> rx_threshold_reached == ($past(rx_fifo_bytes) >= 7'd4 + 7'd4 * $past(queue_fill_threshold));
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("rx threshold flag wrong");

   property p_tx_flag;
      !reset |=> tx_threshold_reached == ($past(tx_fifo_bytes) >= 7'd61 - 7'd4 * $past(queue_fill_threshold));
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("tx threshold flag wrong");

   property p_atten;
      s_write_thr ##1 !reg_write |=> rx_atten_db == 5'd6 * $past(fifo_threshold_config[5:4]);
   endproperty
   a_atten: assert property (p_atten) else $error("attenuation wrong");
endmodule : gpcft_config_bank
`default_nettype wire

// file: tb/gpcft_host_model.sv
// Host microcontroller watching one output pin and timing its level changes
`timescale 1ns/1ps
`default_nettype none
module gpcft_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pin as driven by the device
   input wire logic level,
   input wire logic oe,
   // What the host sees
   output logic wire_level,
   output logic [8:0] half_len
);
   logic [8:0] cnt;
   logic next_wire;
   // Undriven pin wanders so a stale value never passes
   assign next_wire = oe ? level : ~wire_level;
   always_ff @(posedge clk) begin
      if (reset) begin
         wire_level <= 1'b0;
         cnt <= 9'h001;
         half_len <= 9'h000;
      end else begin
         wire_level <= next_wire;
         if (next_wire != wire_level) begin
            half_len <= cnt;
            cnt <= 9'h001;
         end else begin
            cnt <= cnt + 9'h001;
         end
      end
   end
endmodule : gpcft_host_model
`default_nettype wire

// file: tb/gpcft_config_bank_tb.sv
// Register access testbench for the output pin and FIFO threshold bank
`timescale 1ns/1ps
`default_nettype none
module gpcft_config_bank_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic sleep = 1'b0;
   logic [63:0] sources = '0;
   logic chip_ready_low = 1'b1;
   logic [6:0] tx_fifo_bytes = 7'h00;
   logic [6:0] rx_fifo_bytes = 7'h00;
   logic p2, p2_oe, p1, p1_oe, p0, p0_oe, ds, temp_en, keep, tx_flag, rx_flag, host_seen;
   logic [4:0] atten;
   logic [8:0] host_half;
   int fail_count = 0;
   int samples_checked = 0;

   always #20 clk = ~clk;

   gpcft_config_bank u_dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep(sleep),
      .sources(sources), .chip_ready_low(chip_ready_low), .tx_fifo_bytes(tx_fifo_bytes),
      .rx_fifo_bytes(rx_fifo_bytes), .gp_output_two(p2), .gp_output_two_oe(p2_oe),
      .gp_output_one(p1), .gp_output_one_oe(p1_oe), .gp_output_zero(p0),
      .gp_output_zero_oe(p0_oe), .output_drive_strength(ds), .temp_sensor_enable(temp_en),
      .converter_keep_setting(keep), .rx_atten_db(atten),
      .tx_threshold_reached(tx_flag), .rx_threshold_reached(rx_flag)
   );

   gpcft_host_model u_host (
      .clk(clk), .reset(reset), .level(p0), .oe(p0_oe), .wire_level(host_seen), .half_len(host_half)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : ticks

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : rd

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   initial begin
      logic [3:0] code;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(6'h00, 8'h29);
      rd(6'h01, 8'h2E);
      rd(6'h02, 8'h3F);
      rd(6'h03, 8'h07);
      rd(6'h04, 8'h00);
      ticks(2);
      check(8'(p1_oe), 8'h00);
      check({p2_oe, p2}, 8'h03);
      @(posedge clk);
      chip_ready_low <= 1'b0;
      ticks(2);
      check(8'(p2), 8'h00);
      ticks(400);
      check(8'(host_half), 8'h60);
      wr(6'h00, 8'h69);
      ticks(2);
      check(8'(p2), 8'h01);
      rd(6'h00, 8'h69);
      wr(6'h00, 8'hFF);
      rd(6'h00, 8'h7F);
      @(posedge clk);
      sources[0] <= 1'b1;
      wr(6'h01, 8'h80);
      ticks(2);
      check({ds, p1_oe, p1}, 8'h07);
      wr(6'h01, 8'hC0);
      ticks(2);
      check(8'(p1), 8'h00);
      // Clock output off first: it disturbs the radio
      wr(6'h02, 8'h00);
      ticks(2);
      check({p0_oe, p0, host_seen}, 8'h07);
      wr(6'h02, 8'h80);
      ticks(2);
      check({temp_en, p0_oe}, 8'h02);
      wr(6'h03, 8'h40);
      @(posedge clk);
      sleep <= 1'b1;
      ticks(5);
      rd(6'h00, 8'h7F);
      rd(6'h01, 8'hC0);
      rd(6'h02, 8'h80);
      rd(6'h03, 8'h40);
      check(8'(keep), 8'h01);
      @(posedge clk);
      sleep <= 1'b0;
      for (int t = 0; t < 16; t++) begin
         code = 4'(t);
         wr(6'h03, {2'b00, code[1:0], code});
         @(posedge clk);
         rx_fifo_bytes <= 7'(4 + 4 * t);
         tx_fifo_bytes <= 7'(61 - 4 * t);
         ticks(2);
         check({rx_flag, tx_flag}, 8'h03);
         check(8'(atten), 8'(6 * code[1:0]));
         @(posedge clk);
         rx_fifo_bytes <= 7'(3 + 4 * t);
         tx_fifo_bytes <= 7'(60 - 4 * t);
         ticks(2);
         check({rx_flag, tx_flag}, 8'h00);
      end
      // Second reset with every register off its default
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(6'h00, 8'h29);
      rd(6'h01, 8'h2E);
      rd(6'h02, 8'h3F);
      rd(6'h03, 8'h07);
      check({rx_flag, tx_flag}, 8'h02);
      check({p2_oe, p2, p1_oe}, 8'h04);
      final_report();
   end

   // Tests need about 600 cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end
endmodule : gpcft_config_bank_tb
`default_nettype wire
